// ==== hw/dual_rail_reset_sequencer.sv ====
// Top of the dual rail reset sequencer: channel enables, reset timers, watchdog.
// Assumes comparator results and the kick pin are asynchronous pins.
`timescale 1ns/100ps
`include "seq_map.svh"
module dual_rail_reset_sequencer #(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        select_high,
	input  wire logic        select_low,
	input  wire logic        ch1_above_threshold,
	input  wire logic        ch2_above_threshold,
	input  wire logic [19:0] reset_ticks,
	input  wire logic [19:0] window_upper_ticks,
	input  wire logic        watchdog_kick_in,
	output logic             ch1_enable,
	output logic             ch2_enable,
	output logic             reset_out_ch1,
	output logic             reset_out_ch2,
	output logic             watchdog_fault_out
);
	import seq_pkg::*;
	logic [1:0]  sync_hi, sync_lo, sync_v1, sync_v2, sync_k;
	logic        kick_prev;
	sel_mode_t   mode;
	logic        mode_latched;
	logic [1:0]  settle;
	logic [15:0] tick_div;
	logic        tick;
	logic [19:0] timer1, timer2;
	logic        done1, done2;
	logic        valid1, valid2;
	logic        run1, run2;
	logic [19:0] reset_period;
	wd_if        wd ();

	// Two-flop synchronisers for the select, comparator and kick pins
	always_ff @(posedge mclk) begin
		if (srst) begin
			sync_hi <= '0;
			sync_lo <= '0;
			sync_v1 <= '0;
			sync_v2 <= '0;
			sync_k  <= 2'h3;
		end else begin
			sync_hi <= {sync_hi[0], select_high};
			sync_lo <= {sync_lo[0], select_low};
			sync_v1 <= {sync_v1[0], ch1_above_threshold};
			sync_v2 <= {sync_v2[0], ch2_above_threshold};
			sync_k  <= {sync_k[0], watchdog_kick_in};
		end
	end
	assign valid1 = sync_v1[1];
	assign valid2 = sync_v2[1];

	// Select latched once both sync flops hold the pin, before any channel enable; open pin reads neither
	always_ff @(posedge mclk) begin
		if (srst) begin
			mode         <= SEL_OPEN;
			mode_latched <= 1'b0;
			settle       <= '0;
		end else if (!mode_latched) begin
			if (settle != 2'h2) begin
				settle <= settle + 2'h1; // Sync flops still carry their reset values
			end else begin
				mode_latched <= 1'b1;
				if (sync_hi[1])
					mode <= SEL_HIGH;
				else if (sync_lo[1])
					mode <= SEL_LOW;
				else
					mode <= SEL_OPEN;
			end
		end
	end

	// Common timebase enable pulse
	always_ff @(posedge mclk) begin
		if (srst) begin
			tick_div <= '0;
			tick     <= 1'b0;
		end else if (tick_div == 16'(TICK_CYCLES - 1)) begin
			tick_div <= '0;
			tick     <= 1'b1;
		end else begin
			tick_div <= tick_div + 16'h1;
			tick     <= 1'b0;
		end
	end

	// Channel enables; open mode starts both together
	always_ff @(posedge mclk) begin
		if (srst) begin
			ch1_enable <= 1'b0;
			ch2_enable <= 1'b0;
		end else if (mode_latched) begin
			ch1_enable <= 1'b1;
			if (mode == SEL_OPEN)
				ch2_enable <= 1'b1;
			else
				ch2_enable <= valid1;
		end
	end

	// Zero setting means no capacitor: fall back to the minimum
	assign reset_period = (reset_ticks == 20'h0) ? 20'(`RESET_MIN_TICKS) : reset_ticks;
	assign run1 = (mode == SEL_LOW) ? (valid1 && valid2) : valid1;
	assign run2 = valid2;

	// Timer 1; restarts from zero whenever its condition drops
	always_ff @(posedge mclk) begin
		if (srst || !mode_latched || !run1) begin
			timer1 <= '0;
			done1  <= 1'b0;
		end else if (tick && !done1) begin
			if (timer1 + 20'h1 >= reset_period)
				done1 <= 1'b1;
			timer1 <= timer1 + 20'h1;
		end
	end

	// Timer 2 unused in low mode
	always_ff @(posedge mclk) begin
		if (srst || !mode_latched || !run2 || mode == SEL_LOW) begin
			timer2 <= '0;
			done2  <= 1'b0;
		end else if (tick && !done2) begin
			if (timer2 + 20'h1 >= reset_period)
				done2 <= 1'b1;
			timer2 <= timer2 + 20'h1;
		end
	end

	// Reset outputs, high active means held in reset
	always_ff @(posedge mclk) begin
		if (srst) begin
			reset_out_ch1 <= 1'b1;
			reset_out_ch2 <= 1'b1;
		end else if (mode == SEL_LOW) begin
			reset_out_ch1 <= !(done1 && valid1);
			reset_out_ch2 <= !(done1 && valid2);
		end else begin
			reset_out_ch1 <= !(done1 && valid1);
			reset_out_ch2 <= !(done2 && valid2);
		end
	end

	// Kick falling edge detect, read from second flop only
	always_ff @(posedge mclk) begin
		if (srst)
			kick_prev <= 1'b1;
		else
			kick_prev <= sync_k[1];
	end

	// Watchdog enable per mode; reset 2 only stops it in the tied modes
	always_comb begin
		case (mode)
			SEL_HIGH: wd.enable = done1 && done2;
			SEL_LOW:  wd.enable = done1;
			SEL_OPEN: wd.enable = done1;
			default:  wd.enable = 1'b0;
		endcase
		if (reset_out_ch1 || (reset_out_ch2 && mode != SEL_OPEN) || !mode_latched)
			wd.enable = 1'b0;
	end
	assign wd.tick        = tick;
	assign wd.kick_fall   = kick_prev && !sync_k[1];
	assign wd.upper_ticks = (window_upper_ticks == 20'h0) ? 20'(`WIN_UPPER_MIN_TICKS)
	                                                      : window_upper_ticks;

	window_watchdog u_dog (
		.mclk (mclk),
		.srst (srst),
		.wd   (wd.dog)
	);

	// Registered fault output
	always_ff @(posedge mclk) begin
		if (srst)
			watchdog_fault_out <= 1'b0;
		else
			watchdog_fault_out <= wd.fault;
	end
endmodule

// ==== hw/seq_map.svh ====
// Timing and encoding constants for the dual rail reset sequencer.
// Assumes a 100 MHz mclk; the tick is converted to cycles here, all other times to 1 us ticks.
// Operation
// - Tied select: channel 1 first, channel 2 waits
// - Open select: both channels start together
// - High: channel 1 timer starts at threshold
// - High/open: independent channel 2 timer
// - High: watchdog waits for both timers
// - Low: shared timer runs while both valid
// - Low: timer 1 releases both resets, watchdog
// - Open: watchdog enabled after timer 1 only
// - Reset period scales with programmed setting
// - Unprogrammed reset period about 65 us
// - Window upper bound is programmable
// - Lower bound is upper bound over 16
// - Fault pulse is upper bound over 8
// - Unprogrammed upper bound about 200 us
// - Reset held while channel below threshold
// - Invalid channel clears its running timer
// - More than two fast kicks cause fault
// - No kick within upper bound causes fault
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH
`define CLK_MHZ            100
`define TICK_NS            1000
`define TICK_CYCLES        ((`TICK_NS * `CLK_MHZ) / 1000)
`define RESET_MIN_US       65
`define RESET_MIN_TICKS    `RESET_MIN_US
`define WIN_UPPER_MIN_US   200
`define WIN_UPPER_MIN_TICKS `WIN_UPPER_MIN_US
`define LOWER_SHIFT        4
`define FAULT_SHIFT        3
`define FAST_KICK_LIMIT    2
`endif

// ==== hw/seq_pkg.sv ====
// Types shared by the sequencer files.
// Assumes seq_map.svh supplies the numeric constants.
package seq_pkg;
	typedef enum logic [1:0] {
		SEL_LOW  = 2'b00,
		SEL_HIGH = 2'b01,
		SEL_OPEN = 2'b10
	} sel_mode_t;
	typedef enum logic [1:0] {
		WD_OFF   = 2'b00,
		WD_WATCH = 2'b01,
		WD_FAULT = 2'b10
	} wd_state_t;
endpackage

// ==== hw/wd_if.sv ====
// Carrier between the sequencer top and its watchdog.
// Assumes one mclk domain on both sides.
`timescale 1ns/100ps
interface wd_if;
	logic        enable;
	logic        tick;
	logic        kick_fall;
	logic [19:0] upper_ticks;
	logic        fault;
	modport top (output enable, output tick, output kick_fall, output upper_ticks, input fault);
	modport dog (input enable, input tick, input kick_fall, input upper_ticks, output fault);
endinterface

// ==== hw/window_watchdog.sv ====
// Window watchdog counted on the shared timebase tick.
// Assumes kick_fall is already synchronised and one cycle wide.
`timescale 1ns/100ps
`include "seq_map.svh"
module window_watchdog (
	input  wire logic mclk,
	input  wire logic srst,
	wd_if.dog         wd
);
	import seq_pkg::*;
	wd_state_t   state;
	logic [19:0] elapsed;
	logic [1:0]  fast_kicks;
	logic [19:0] lower_ticks;
	logic [19:0] fault_ticks;

	// Derived bounds share one programmed base
	assign lower_ticks = wd.upper_ticks >> `LOWER_SHIFT;
	assign fault_ticks = wd.upper_ticks >> `FAULT_SHIFT;
	assign wd.fault    = (state == WD_FAULT);

	// Window tracking; kicks during the fault pulse are ignored
	always_ff @(posedge mclk) begin
		if (srst || !wd.enable) begin
			state      <= WD_OFF;
			elapsed    <= '0;
			fast_kicks <= '0;
		end else begin
			case (state)
				WD_OFF: begin
					state      <= WD_WATCH;
					elapsed    <= '0;
					fast_kicks <= '0;
				end
				WD_WATCH: begin
					if (wd.kick_fall) begin
						if (elapsed < lower_ticks && fast_kicks == 2'(`FAST_KICK_LIMIT)) begin
							state   <= WD_FAULT;
							elapsed <= '0;
						end else if (elapsed < lower_ticks) begin
							fast_kicks <= fast_kicks + 2'h1;
							// A tick in the kick cycle still counts, so the window does not stretch
							if (wd.tick)
								elapsed <= elapsed + 20'h1;
						end else begin
							elapsed    <= '0;
							fast_kicks <= '0;
						end
					end else if (wd.tick) begin
						if (elapsed + 20'h1 >= wd.upper_ticks) begin
							state   <= WD_FAULT;
							elapsed <= '0;
						end else begin
							elapsed <= elapsed + 20'h1;
						end
					end
				end
				WD_FAULT: begin
					if (wd.tick) begin
						if (elapsed + 20'h1 >= fault_ticks) begin
							state      <= WD_WATCH;
							elapsed    <= '0;
							fast_kicks <= '0;
						end else begin
							elapsed <= elapsed + 20'h1;
						end
					end
				end
				default: state <= WD_OFF;
			endcase
		end
	end
endmodule

// ==== sim/seq_checker.sv ====
// Port assertions for the dual rail reset sequencer.
// Assumes select pins only change while srst is high.
`timescale 1ns/100ps
`include "seq_map.svh"
module seq_checker #(
	parameter int TICK_CYCLES = 2
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic select_high,
	input wire logic select_low,
	input wire logic ch1_above_threshold,
	input wire logic ch2_above_threshold,
	input wire logic [19:0] window_upper_ticks,
	input wire logic ch1_enable,
	input wire logic ch2_enable,
	input wire logic reset_out_ch1,
	input wire logic reset_out_ch2,
	input wire logic watchdog_fault_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// Select tied either way means ordered start
	wire tied = select_high | select_low;
	// Expected fault span from the programmed upper bound; tick phase may shave one tick
	logic [19:0] fault_span;
	int          fault_len;
	int          fault_lo;
	int          fault_hi;
	assign fault_span = ((window_upper_ticks == 20'h0) ? 20'(`WIN_UPPER_MIN_TICKS) : window_upper_ticks)
		>> `FAULT_SHIFT;
	assign fault_hi = int'(fault_span) * TICK_CYCLES;
	assign fault_lo = fault_hi - TICK_CYCLES + 1;
	always_ff @(posedge mclk) fault_len <= watchdog_fault_out ? fault_len + 1 : 0;
	a_reset_state: assert property ($fell(srst) |-> reset_out_ch1 && reset_out_ch2 && !ch1_enable
		&& !watchdog_fault_out) else $error("outputs wrong after reset");
	a_ch2_after_ch1: assert property (tied && !ch1_enable |-> !ch2_enable) else $error("ch2 early");
	a_open_together: assert property (!tied |-> ch1_enable == ch2_enable) else $error("open order");
	// Slack covers two sync flops and the output register
	a_ch1_hold: assert property (!ch1_above_threshold [*5] |-> reset_out_ch1) else $error("reset_out_ch1 low");
	a_ch2_hold: assert property (!ch2_above_threshold [*5] |-> reset_out_ch2) else $error("reset_out_ch2 low");
	a_low_together: assert property (select_low && !select_high && $fell(reset_out_ch1)
		|-> $fell(reset_out_ch2)) else $error("low mode split release");
	a_fault_after_reset_out_ch1: assert property ($rose(watchdog_fault_out) |-> !$past(reset_out_ch1))
		else $error("watchdog before timer 1");
	a_fault_after_both: assert property (tied && $rose(watchdog_fault_out) |-> !$past(reset_out_ch2))
		else $error("watchdog before timer 2");
	// A reset that stops the watchdog may cut a fault short, so those ends are skipped
	a_fault_width: assert property ($fell(watchdog_fault_out) && !reset_out_ch1
		&& !(tied && reset_out_ch2) |-> fault_len inside {[fault_lo:fault_hi]}) else $error("fault width");
endmodule
bind dual_rail_reset_sequencer seq_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (.mclk(mclk), .srst(srst),
	.select_high(select_high), .select_low(select_low), .ch1_above_threshold(ch1_above_threshold),
	.ch2_above_threshold(ch2_above_threshold), .window_upper_ticks(window_upper_ticks),
	.ch1_enable(ch1_enable), .ch2_enable(ch2_enable),
	.reset_out_ch1(reset_out_ch1), .reset_out_ch2(reset_out_ch2), .watchdog_fault_out(watchdog_fault_out));

// ==== sim/tb.sv ====
// Self-checking bench for the dual rail reset sequencer.
// Assumes TICK_CYCLES of 2, so one tick is two mclk cycles.
`timescale 1ns/100ps
module tb;
	logic        mclk = 0, srst = 1, sh = 0, sl = 0, v1 = 0, v2 = 0, quiet = 0, burst = 0;
	logic [19:0] rticks = 20'h4, wticks = 20'h20;
	logic        kick, en1, en2, r1, r2, wdf;
	int          n_errors = 0, checks = 0, cyc = 0, n, hits;
	always #5 mclk = ~mclk;
	dual_rail_reset_sequencer #(.TICK_CYCLES(2)) dut (.mclk(mclk), .srst(srst), .select_high(sh),
		.select_low(sl), .ch1_above_threshold(v1), .ch2_above_threshold(v2), .reset_ticks(rticks),
		.window_upper_ticks(wticks), .watchdog_kick_in(kick), .ch1_enable(en1), .ch2_enable(en2),
		.reset_out_ch1(r1), .reset_out_ch2(r2), .watchdog_fault_out(wdf));
	uproc_model cpu (.mclk(mclk), .reset_out_ch1(r1), .quiet(quiet), .burst(burst), .kick(kick));
	task chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s exp %0h seen %0h", what, exp, seen);
		end
	endtask
	task results;
		if (n_errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Hang guard well above the roughly 1500 cycles needed
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 8000) begin
			n_errors++;
			results;
		end
	end
	task step(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	// Select is set under reset so it is latched before any ramp
	task start(input logic h, input logic l);
		srst = 1;
		v1 = 0;
		v2 = 0;
		quiet = 0;
		sh = h;
		sl = l;
		step(5);
		srst = 0;
		step(8);
		chk("en1", en1, 1);
		chk("en2", en2, !(h | l));
	endtask
	task wait_rel(input bit which);
		for (n = 0; n < 400 && (which ? r2 : r1) !== 1'b0; n++) step(1);
	endtask
	task watch(input int len);
		hits = 0;
		repeat (len) begin
			step(1);
			hits += wdf;
		end
	endtask
	task mode_high;
		start(1, 0);
		v1 = 1;
		step(4);
		chk("en2", en2, 1);
		wait_rel(0);
		// Period of 8 cycles plus sync, less the 4 cycles already waited
		chk("rel1", n inside {[5:8]}, 1);
		chk("reset_out_ch2", r2, 1);
		v2 = 1;
		wait_rel(1);
		chk("rel2", n inside {[8:14]}, 1);
		watch(300);
		chk("kicked", hits, 0);
		quiet = 1;
		watch(160);
		chk("silent", hits inside {[14:18]}, 1);
	endtask
	task mode_low;
		wticks = 20'h80; // Lower bound of 16 cycles, so the burst lands three fast kicks
		start(0, 1);
		v1 = 1;
		step(4);
		chk("en2", en2, 1);
		step(30);
		chk("reset_out_ch1", r1, 1);
		v2 = 1;
		wait_rel(0);
		chk("rel", n inside {[8:14]}, 1);
		chk("reset_out_ch2", r2, 0);
		watch(100);
		chk("kicked", hits, 0);
		burst = 1;
		watch(16);
		burst = 0;
		chk("burst", hits > 0, 1);
	endtask
	// Channel 1 drops mid-count; the full period must follow recovery
	task mode_open;
		wticks = 20'h20;
		start(0, 0);
		v1 = 1;
		step(5);
		v1 = 0;
		step(4);
		v1 = 1;
		wait_rel(0);
		chk("restart", n inside {[8:14]}, 1);
		chk("reset_out_ch2", r2, 1);
		quiet = 1;
		watch(160);
		chk("dog", hits inside {[14:18]}, 1);
	endtask
	task defaults;
		rticks = 20'h0;
		wticks = 20'h0;
		start(1, 0);
		v1 = 1;
		v2 = 1;
		quiet = 1;
		wait_rel(0);
		chk("rel", n inside {[128:138]}, 1);
		watch(500);
		chk("fault", hits inside {[48:52]}, 1);
	endtask
	initial begin
		mode_high;
		mode_low;
		mode_open;
		defaults;
		results;
	end
endmodule

// ==== sim/uproc_model.sv ====
// Processor model: kicks the watchdog once reset 1 is released.
// Assumes the kick pin idles high through its pull-up.
`timescale 1ns/100ps
module uproc_model #(
	parameter int GAP = 20
) (
	input  wire logic mclk,
	input  wire logic reset_out_ch1,
	input  wire logic quiet,
	input  wire logic burst,
	output logic      kick
);
	int cnt = 0;
	initial kick = 1'b1;
	// Spaced kicks sit inside the window; burst is a runaway loop
	always @(posedge mclk) begin
		cnt <= (cnt >= GAP) ? 0 : cnt + 1;
		kick <= #1 burst ? !kick : !(cnt == 0 && !reset_out_ch1 && !quiet);
	end
endmodule
